// *** pos_host_model.sv ***
// Host model that issues status reads and ignored writes.
`timescale 1ns/1ps
`default_nettype none
module pos_host_model (
   input  wire logic       ref_clk,
   output logic            rd_i = 1'b0,
   output logic            wr_i = 1'b0,
   output logic [7:0]      cmd_i = 8'h00
);
   // The code is inverted once released, so a stale code is never reused.
   task xfer(input logic r, input logic [7:0] c);
      @(posedge ref_clk) #1 {rd_i, wr_i, cmd_i} = {r, !r, c};
      @(posedge ref_clk) #1 {rd_i, wr_i, cmd_i} = {2'b00, ~c};
   endtask
endmodule // pos_host_model
`default_nettype wire

// *** pos_regs.vh ***
// Command codes, bit positions and reset values for the output and input status bytes.
`ifndef POS_REGS_VH
`define POS_REGS_VH
`define POS_CMD_VOUT_STATUS  8'h7a
`define POS_CMD_IOUT_STATUS  8'h7b
`define POS_CMD_INPUT_STATUS 8'h7c
`define POS_CMD_STATUS_WORD  8'h79
`define POS_STATUS_RESET     8'h00
`define POS_VOLT_OVER_BIT    7
`define POS_VOLT_UNDER_BIT   4
`define POS_VOLT_LIMIT_BIT   3
`define POS_CURR_FAULT_BIT   7
`define POS_CURR_WARN_BIT    5
`define POS_IN_OVF_BIT       7
`define POS_IN_UVF_BIT       4
`define POS_IN_OCF_BIT       2
`define POS_IN_OCW_BIT       1
`define POS_WORD_VOUT_BIT    15
`endif

// *** pos_status_regs.v ***
// Output voltage, output current and input fault status bytes.
`timescale 1ns/1ps
`default_nettype none
`include "pos_regs.vh"
// What this block does
// - Voltage status byte at 7Ah, resets zero.
// - Bit 7 latches output overvoltage fault.
// - Bit 4 latches output undervoltage fault.
// - Voltage bits 6,5,2,1,0 always read zero.
// - Current status byte at 7Bh, resets zero.
// - Bit 7 latches output overcurrent fault.
// - Bit 5 latches output overcurrent warning.
// - Current bits 6,4,3,2,1,0 always read zero.
// - Input status byte at 7Ch, resets zero.
// - All flags except input undervoltage raise alert.
// - Summary bit 15 set by voltage flags.
module pos_status_regs (
   input  wire       ref_clk,          // Controller clock, 25 MHz.
   input  wire       rst_n,            // Asynchronous reset, active low.
   input  wire       ov_fault_i,       // Output overvoltage detected.
   input  wire       uv_fault_i,       // Output undervoltage detected.
   input  wire       vout_req_i,       // Output voltage program request.
   input  wire [7:0] vout_req_code_i,  // Requested output voltage code.
   input  wire [7:0] max_output_voltage_limit_i, // Configured ceiling.
   input  wire       oc_fault_i,       // Output overcurrent fault.
   input  wire       oc_warn_i,        // Output overcurrent warning.
   input  wire       in_ov_fault_i,    // Input overvoltage fault.
   input  wire       in_uv_fault_i,    // Input undervoltage fault.
   input  wire       in_oc_fault_i,    // Input overcurrent fault.
   input  wire       in_oc_warn_i,     // Input overcurrent warning.
   input  wire       clear_faults_i,   // Host clear-faults strobe.
   input  wire       rd_i,             // Host read strobe.
   input  wire       wr_i,             // Host write strobe, ignored.
   input  wire [7:0] cmd_i,            // Command code of the access.
   output reg  [7:0] rd_data_q,        // Byte answered to the read.
   output reg        rd_valid_q,       // Read answer valid, one cycle.
   output reg        summary_vout_q,   // Summary word bit 15.
   output reg        fault_alert_output_q, // Alert request, active high.
   output reg        alert_oe_q        // Open-drain alert pull enable.
);
   // Latched flags, one sticky cell each.
   wire [8:0] flag;
   // Limit comparison happens only on a real request.
   wire       maxw_evt = vout_req_i &&
                         (vout_req_code_i > max_output_voltage_limit_i);
   wire [8:0] set_vec = {in_oc_warn_i, in_oc_fault_i, in_uv_fault_i,
                         in_ov_fault_i, oc_warn_i, oc_fault_i,
                         maxw_evt, uv_fault_i, ov_fault_i};

   // Writes never reach the cells; only clear-faults and reset clear them.
   genvar g;
   generate
      for (g = 0; g < 9; g = g + 1) begin : g_flag
         pos_sticky_flag u_flag (
            .ref_clk (ref_clk),
            .rst_n   (rst_n),
            .set_i   (set_vec[g]),
            .clear_i (clear_faults_i),
            .flag_q  (flag[g])
         );
      end
   endgenerate

   // Assembled bytes; unsupported bits are hard zero.
   reg [7:0] vout_byte;
   reg [7:0] iout_byte;
   reg [7:0] in_byte;
   always @* begin
      vout_byte = `POS_STATUS_RESET;
      vout_byte[`POS_VOLT_OVER_BIT]  = flag[0];
      vout_byte[`POS_VOLT_UNDER_BIT] = flag[1];
      vout_byte[`POS_VOLT_LIMIT_BIT] = flag[2];
      iout_byte = `POS_STATUS_RESET;
      iout_byte[`POS_CURR_FAULT_BIT] = flag[3];
      iout_byte[`POS_CURR_WARN_BIT]  = flag[4];
      in_byte = `POS_STATUS_RESET;
      in_byte[`POS_IN_OVF_BIT] = flag[5];
      in_byte[`POS_IN_UVF_BIT] = flag[6];
      in_byte[`POS_IN_OCF_BIT] = flag[7];
      in_byte[`POS_IN_OCW_BIT] = flag[8];
   end

   // Read answer is registered; unknown codes answer zero.
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data_q  <= `POS_STATUS_RESET;
         rd_valid_q <= 1'b0;
      end else begin
         rd_valid_q <= rd_i;
         if (rd_i) begin
            case (cmd_i)
               `POS_CMD_VOUT_STATUS:  rd_data_q <= vout_byte;
               `POS_CMD_IOUT_STATUS:  rd_data_q <= iout_byte;
               `POS_CMD_INPUT_STATUS: rd_data_q <= in_byte;
               default:               rd_data_q <= `POS_STATUS_RESET;
            endcase
         end
      end
   end

   // Summary and alert follow the flags one cycle late.
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         summary_vout_q       <= 1'b0;
         fault_alert_output_q <= 1'b0;
         alert_oe_q           <= 1'b0;
      end else begin
         summary_vout_q <= |vout_byte;
         // Input undervoltage is left out: it is normal at power-up.
         fault_alert_output_q <= |{flag[8:7], flag[5:0]};
         alert_oe_q           <= |{flag[8:7], flag[5:0]};
      end
   end
endmodule // pos_status_regs
`default_nettype wire

// *** pos_status_regs_checker.sv ***
// Checker for the status byte ports.
`timescale 1ns/1ps
`default_nettype none
module pos_status_regs_checker (input wire ref_clk, rst_n, ov_fault_i,
   uv_fault_i, oc_fault_i, clear_faults_i, rd_i, rd_valid_q, summary_vout_q,
   fault_alert_output_q, alert_oe_q, input wire [7:0] cmd_i, rd_data_q);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   chk_read_answer: assert property (rd_i |=> rd_valid_q)
      else $error("read not answered");
   chk_vout_zeros: assert property (rd_valid_q && $past(cmd_i) == 8'h7a
      |-> (rd_data_q & 8'h67) == 8'h00) else $error("voltage bit set");
   chk_iout_zeros: assert property (rd_valid_q && $past(cmd_i) == 8'h7b
      |-> (rd_data_q & 8'h5f) == 8'h00) else $error("current bit set");
   chk_ov_latch: assert property (ov_fault_i ##1 rd_i && cmd_i == 8'h7a
      && !clear_faults_i |=> rd_data_q[7]) else $error("ov not latched");
   chk_uv_latch: assert property (uv_fault_i ##1 rd_i && cmd_i == 8'h7a
      && !clear_faults_i |=> rd_data_q[4]) else $error("uv not latched");
   chk_summary_set: assert property (ov_fault_i ##1 !clear_faults_i
      |=> summary_vout_q) else $error("summary not set");
   chk_alert_set: assert property (oc_fault_i ##1 !clear_faults_i
      |=> fault_alert_output_q && alert_oe_q) else $error("alert not set");
   chk_flag_hold: assert property (summary_vout_q && !clear_faults_i
      && !$past(clear_faults_i) |=> summary_vout_q) else $error("flag lost");
endmodule // pos_status_regs_checker
bind pos_status_regs pos_status_regs_checker pos_status_regs_checker_i (.*);
`default_nettype wire

// *** pos_sticky_flag.v ***
// One sticky status flag with set-over-clear priority.
`timescale 1ns/1ps
`default_nettype none
module pos_sticky_flag (
   input  wire ref_clk,   // Controller clock.
   input  wire rst_n,     // Asynchronous reset, active low.
   input  wire set_i,     // Fault event, one cycle or level.
   input  wire clear_i,   // Clear-faults strobe.
   output reg  flag_q     // Latched flag.
);
   // A set in the clear cycle wins so that no event is lost.
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         flag_q <= 1'b0;
      end else if (set_i) begin
         flag_q <= 1'b1;
      end else if (clear_i) begin
         flag_q <= 1'b0;
      end
   end
endmodule // pos_sticky_flag
`default_nettype wire

// *** tb_top.sv ***
// Bench for the status byte block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic ref_clk = 0, rst_n = 0, clr = 0, req = 0, m, rv, sv, al, oe, wr, rd;
   logic [7:0] ev = 0, code = 0, lim = 0, e, cmd, rdat, q[$];
   logic [31:0] s = 53847;
   int fail_count = 0, compares = 0, cyc = 0;
   always #20 ref_clk = ~ref_clk;
   pos_host_model pos_host_model_i (.ref_clk, .rd_i(rd), .wr_i(wr), .cmd_i(cmd));
   pos_status_regs pos_status_regs_i (.ref_clk, .rst_n, .ov_fault_i(ev[0]),
      .uv_fault_i(ev[1]), .oc_fault_i(ev[2]), .oc_warn_i(ev[3]),
      .in_ov_fault_i(ev[4]), .in_uv_fault_i(ev[5]), .in_oc_fault_i(ev[6]),
      .in_oc_warn_i(ev[7]), .vout_req_i(req), .vout_req_code_i(code),
      .max_output_voltage_limit_i(lim), .clear_faults_i(clr), .rd_i(rd),
      .wr_i(wr), .cmd_i(cmd), .rd_data_q(rdat), .rd_valid_q(rv),
      .summary_vout_q(sv), .fault_alert_output_q(al), .alert_oe_q(oe));
   task chk(input logic [7:0] x, y);
      compares++;
      if (x !== y) begin
         fail_count++;
         $display("wrong value t=%0t exp=%h got=%h", $time, x, y);
      end
   endtask
   task tally_and_finish;
      if (fail_count == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // Each read answer is matched with the oldest expected byte.
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc > 3000) begin fail_count++; tally_and_finish; end
      if (rv === 1'b1) chk(q.size() ? q.pop_front() : 8'hxx, rdat);
   end
   task pair(input logic [7:0] c, x);
      q.push_back(x);
      pos_host_model_i.xfer(1'b1, c);
   endtask
   initial begin
      repeat (10) @(posedge ref_clk);
      #1 rst_n = 1;
      for (int i = 0; i < 8; i++) begin
         s ^= s << 13; s ^= s >> 17; s ^= s << 5;
         e = (i == 0) ? 8'h00 : (i == 1) ? 8'h20 : s[7:0];
         @(posedge ref_clk) #1 {ev, req, code, lim} = {e, i != 0, s[23:8]};
         m = req && code > lim;
         @(posedge ref_clk) #1 {ev, req} = 9'h000;
         pos_host_model_i.xfer(1'b0, 8'h7a);
         chk({7'h0, |{e[7:6], e[4:0], m}}, {7'h0, al & oe});
         chk({7'h0, e[0] | e[1] | m}, {7'h0, sv});
         pair(8'h7a, {e[0], 2'b0, e[1], m, 3'b0});
         pair(8'h7b, {e[2], 1'b0, e[3], 5'b0});
         pair(8'h7c, {e[4], 2'b0, e[5], 1'b0, e[6], e[7], 1'b0});
         pair(8'h7d, 8'h00);
         @(posedge ref_clk) #1 clr = 1;
         @(posedge ref_clk) #1 clr = 0;
      end
      repeat (3) @(posedge ref_clk);
      tally_and_finish;
   end
endmodule // tb_top
`default_nettype wire
